// [inc/fdcr_defs.svh]
/*
 * Register offsets, field positions, reset values and timing counts for the
 * flash driver control registers 5 and 6 and the privacy indicator decode.
 * Assumes inclusion by bare name from files that need these constants.
 */

`ifndef FDCR_DEFS_SVH
`define FDCR_DEFS_SVH

// Register offsets
`define FDCR_OFS_REG5 8'h05
`define FDCR_OFS_REG6 8'h06

// Reset values
`define FDCR_RST_REG5 8'h6a
`define FDCR_RST_REG6 8'h09

// Register 5 fields
`define FDCR_R5_CAL 7
`define FDCR_R5_PSM 6
`define FDCR_R5_DIR 5
`define FDCR_R5_VAL 4
`define FDCR_R5_TYPE 3
`define FDCR_R5_LED_HI 2
`define FDCR_R5_LED_LO 0

// Register 6 fields
`define FDCR_R6_TMON 7
`define FDCR_R6_HOT 6
`define FDCR_R6_WARN 5
`define FDCR_R6_HDR 4
`define FDCR_R6_OV_HI 3
`define FDCR_R6_OV_LO 0
`define FDCR_R6_SPARE_HI 7
`define FDCR_R6_SPARE_LO 5

// Operating mode select that permits PWM indication
`define FDCR_MODE_PWM_OK 2'h1

// Privacy LED current selections
`define FDCR_LVL_OFF 2'h0

// PWM dimming on-counts, in tenths of a percent of the period
`define FDCR_PWM_PERIOD 10'h3e8
`define FDCR_DUTY_0 10'h008
`define FDCR_DUTY_1 10'h010
`define FDCR_DUTY_2 10'h017
`define FDCR_DUTY_3 10'h01f
`define FDCR_DUTY_4 10'h027
`define FDCR_DUTY_5 10'h02f
`define FDCR_DUTY_6 10'h03f
`define FDCR_DUTY_7 10'h056

// PWM step timing: step time in ns and cycles at 10 ns clock
`define FDCR_CLK_PERIOD_NS 10
`define FDCR_PWM_STEP_NS 1000
`define FDCR_PWM_STEP_CYC (`FDCR_PWM_STEP_NS / `FDCR_CLK_PERIOD_NS)

`endif

// [inc/fdcr_pkg.sv]
/*
 * Types shared by the flash driver control register block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package fdcr_pkg;

    // Decoded privacy indicator behaviour
    typedef enum logic [1:0] {
        FDCR_IND_OFF,
        FDCR_IND_DIRECT,
        FDCR_IND_PULLDOWN,
        FDCR_IND_PWM
    } fdcr_ind_mode_t;

endpackage

// [src/fdcr_sync.sv]
/*
 * Two-flop level synchroniser, one lane per bit.
 * Assumes inputs are plain levels from another timing source.
 */
`timescale 1ns/1ps

module fdcr_sync #(
    parameter int WIDTH = 2
) (
    input wire logic core_clk, // Core clock
    input wire logic rst, // Async reset, active high
    input wire logic [WIDTH-1:0] async_in, // Unsynchronised levels
    output logic [WIDTH-1:0] sync_out // Synchronised levels
);

    logic [WIDTH-1:0] stage1_ff;
    logic [WIDTH-1:0] stage2_ff;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            stage1_ff <= '0;
            stage2_ff <= '0;
        end else begin
            stage1_ff <= async_in;
            stage2_ff <= stage1_ff;
        end
    end

    assign sync_out = stage2_ff;

endmodule // fdcr_sync

// [src/fdcr_regs.sv]
/*
 * Control registers 5 and 6 of the flash LED driver, the privacy indicator
 * decode with its PWM dimmer, and the auxiliary pin driver.
 * Assumes an upstream serial byte engine presents register reads and writes
 * as single-cycle strobes on core_clk, and that analog status inputs are
 * produced by the surrounding converter logic.
 */
`timescale 1ns/1ps
`include "fdcr_defs.svh"

module fdcr_regs #(
    parameter bit HAS_THERMAL = 1'b1, // Temperature-monitoring variant
    parameter int PWM_STEP_CYC = `FDCR_PWM_STEP_CYC // Cycles per PWM step
) (
    input wire logic core_clk, // Core clock, 100 MHz
    input wire logic rst, // Async reset, active high
    input wire logic [7:0] reg_addr, // Register address
    input wire logic reg_wr, // Write strobe
    input wire logic [7:0] reg_wdata, // Write data
    input wire logic reg_rd, // Read strobe
    output logic [7:0] reg_rdata, // Read data, valid after strobe
    input wire logic [3:0] indicator_level_code, // Indicator code
    input wire logic [1:0] mode_select, // Operating mode select
    input wire logic high_current_select, // High-current select level
    input wire logic torch_enable_pin, // Torch enable pin level
    input wire logic voltage_mode_force, // Voltage-mode force bit
    output logic [1:0] privacy_led_level, // 0 off, 1..3 current step
    output logic privacy_led_pulldown, // Output node pulled to ground
    output logic [2:0] pwm_channel_on, // PWM indicator gate per channel
    output logic pwm_indicator_active, // PWM indicator mode running
    output logic calibration_enable, // Self-calibration enabled
    output logic calibration_start, // Pulse at (re)start
    input wire logic calibration_done, // Pulse when calibration ends
    input wire logic [3:0] calibration_result, // Calibrated target code
    output logic power_save_enable, // Power-save mode enable
    input wire logic aux_pin_in, // Aux pin input level
    output logic aux_pin_out, // Aux pin output level
    output logic aux_pin_oe_n, // Aux pin enable, low drives
    output logic [2:0] led_channel_enable, // Channel a..c enables
    input wire logic flash_strobe_end, // Pulse before ramp-down
    input wire logic headroom_ok, // Regulator headroom sufficient
    output logic [3:0] target_output_code, // Output voltage target
    output logic constant_voltage_mode, // Constant voltage source
    output logic thermistor_monitor_enable, // Thermistor bias enable
    input wire logic ts_below_hot, // Sense below 0.345 V, async
    input wire logic ts_below_warn, // Sense below 1.05 V, async
    output logic thermal_shutdown // Overheat shutdown latched
);

    // Register 5 state
    logic cal_en_ff;
    logic nxt_cal_en;
    logic cal_done_ff;
    logic nxt_cal_done;
    logic cal_start_ff;
    logic nxt_cal_start;
    logic psm_ff;
    logic nxt_psm;
    logic dir_ff;
    logic nxt_dir;
    logic val_ff;
    logic nxt_val;
    logic type_ff;
    logic nxt_type;
    logic [2:0] led_en_ff;
    logic [2:0] nxt_led_en;

    // Register 6 state
    logic tmon_ff;
    logic nxt_tmon;
    logic hot_ff;
    logic nxt_hot;
    logic warn_ff;
    logic nxt_warn;
    logic hdr_ff;
    logic nxt_hdr;
    logic [3:0] ov_tgt_ff;
    logic [3:0] nxt_ov_tgt;
    logic [3:0] ov_rb_ff;
    logic [3:0] nxt_ov_rb;
    logic [2:0] spare_ff;
    logic [2:0] nxt_spare;
    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata;

    // Indicator state
    logic [15:0] step_cnt_ff;
    logic [15:0] nxt_step_cnt;
    logic [9:0] phase_ff;
    logic [9:0] nxt_phase;
    logic pwm_on_ff;
    logic nxt_pwm_on;
    logic [1:0] lvl_ff;
    logic [1:0] nxt_lvl;
    logic pull_ff;
    logic nxt_pull;

    logic [1:0] temp_sync;
    logic wr5;
    logic wr6;
    logic rd5;
    logic rd6;
    logic step_en;
    logic [9:0] duty;
    fdcr_pkg::fdcr_ind_mode_t ind_mode;

    fdcr_sync #(
        .WIDTH(2)
    ) u_temp_sync (
        .core_clk(core_clk),
        .rst(rst),
        .async_in({ts_below_hot, ts_below_warn}),
        .sync_out(temp_sync)
    );

    assign wr5 = reg_wr && (reg_addr == `FDCR_OFS_REG5);
    assign wr6 = reg_wr && (reg_addr == `FDCR_OFS_REG6);
    assign rd5 = reg_rd && (reg_addr == `FDCR_OFS_REG5);
    assign rd6 = reg_rd && (reg_addr == `FDCR_OFS_REG6);

    // Register update and read capture
    always_comb begin
        nxt_cal_en = cal_en_ff;
        nxt_cal_done = cal_done_ff;
        nxt_cal_start = 1'b0;
        nxt_psm = psm_ff;
        nxt_dir = dir_ff;
        nxt_val = val_ff;
        nxt_type = type_ff;
        nxt_led_en = led_en_ff;
        nxt_tmon = tmon_ff;
        nxt_hot = hot_ff;
        nxt_warn = warn_ff;
        nxt_hdr = hdr_ff;
        nxt_ov_tgt = ov_tgt_ff;
        nxt_ov_rb = ov_rb_ff;
        nxt_spare = spare_ff;
        nxt_rdata = rdata_ff;

        if (wr5) begin
            nxt_cal_en = reg_wdata[`FDCR_R5_CAL];
            if (reg_wdata[`FDCR_R5_CAL]) begin
                nxt_cal_done = 1'b0;
                nxt_cal_start = 1'b1;
            end
            nxt_psm = reg_wdata[`FDCR_R5_PSM];
            nxt_dir = reg_wdata[`FDCR_R5_DIR];
            nxt_val = reg_wdata[`FDCR_R5_VAL];
            nxt_type = reg_wdata[`FDCR_R5_TYPE];
            nxt_led_en = reg_wdata[`FDCR_R5_LED_HI:`FDCR_R5_LED_LO];
        end
        // Input mode: value bit follows the pin
        if (!nxt_dir) begin
            nxt_val = aux_pin_in;
        end
        // Done set wins over a start in the same cycle
        if (calibration_done && cal_en_ff) begin
            nxt_cal_done = 1'b1;
            nxt_ov_rb = calibration_result;
            nxt_ov_tgt = calibration_result;
        end

        if (wr6) begin
            nxt_ov_tgt = reg_wdata[`FDCR_R6_OV_HI:`FDCR_R6_OV_LO];
            if (!(calibration_done && cal_en_ff)) begin
                nxt_ov_rb = reg_wdata[`FDCR_R6_OV_HI:`FDCR_R6_OV_LO];
            end
            if (HAS_THERMAL) begin
                nxt_tmon = reg_wdata[`FDCR_R6_TMON];
                if (!reg_wdata[`FDCR_R6_HOT]) begin
                    nxt_hot = 1'b0;
                end
            end else begin
                nxt_spare = reg_wdata[`FDCR_R6_SPARE_HI:`FDCR_R6_SPARE_LO];
            end
        end
        if (flash_strobe_end) begin
            nxt_hdr = headroom_ok;
        end

        // Read data captured before any clear-on-read
        if (rd5) begin
            nxt_rdata = {cal_done_ff, psm_ff, torch_enable_pin, val_ff,
                         type_ff, led_en_ff};
        end else if (rd6) begin
            if (HAS_THERMAL) begin
                nxt_rdata = {tmon_ff, hot_ff, warn_ff, hdr_ff, ov_rb_ff};
            end else begin
                nxt_rdata = {spare_ff, hdr_ff, ov_rb_ff};
            end
        end else if (reg_rd) begin
            nxt_rdata = 8'h00;
        end
        if (rd6 && HAS_THERMAL) begin
            nxt_warn = 1'b0;
        end

        // Comparator sets win over any clear in the same cycle
        if (HAS_THERMAL && tmon_ff) begin
            if (temp_sync[1]) begin
                nxt_hot = 1'b1;
            end
            if (temp_sync[0]) begin
                nxt_warn = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cal_en_ff <= 1'(`FDCR_RST_REG5 >> `FDCR_R5_CAL);
            cal_done_ff <= 1'b0;
            cal_start_ff <= 1'b0;
            psm_ff <= 1'(`FDCR_RST_REG5 >> `FDCR_R5_PSM);
            dir_ff <= 1'(`FDCR_RST_REG5 >> `FDCR_R5_DIR);
            val_ff <= 1'(`FDCR_RST_REG5 >> `FDCR_R5_VAL);
            type_ff <= 1'(`FDCR_RST_REG5 >> `FDCR_R5_TYPE);
            led_en_ff <= 3'(`FDCR_RST_REG5 >> `FDCR_R5_LED_LO);
            tmon_ff <= 1'(`FDCR_RST_REG6 >> `FDCR_R6_TMON);
            hot_ff <= 1'(`FDCR_RST_REG6 >> `FDCR_R6_HOT);
            warn_ff <= 1'(`FDCR_RST_REG6 >> `FDCR_R6_WARN);
            hdr_ff <= 1'(`FDCR_RST_REG6 >> `FDCR_R6_HDR);
            ov_tgt_ff <= 4'(`FDCR_RST_REG6 >> `FDCR_R6_OV_LO);
            ov_rb_ff <= 4'(`FDCR_RST_REG6 >> `FDCR_R6_OV_LO);
            spare_ff <= 3'(`FDCR_RST_REG6 >> `FDCR_R6_SPARE_LO);
            rdata_ff <= 8'h00;
        end else begin
            cal_en_ff <= nxt_cal_en;
            cal_done_ff <= nxt_cal_done;
            cal_start_ff <= nxt_cal_start;
            psm_ff <= nxt_psm;
            dir_ff <= nxt_dir;
            val_ff <= nxt_val;
            type_ff <= nxt_type;
            led_en_ff <= nxt_led_en;
            tmon_ff <= nxt_tmon;
            hot_ff <= nxt_hot;
            warn_ff <= nxt_warn;
            hdr_ff <= nxt_hdr;
            ov_tgt_ff <= nxt_ov_tgt;
            ov_rb_ff <= nxt_ov_rb;
            spare_ff <= nxt_spare;
            rdata_ff <= nxt_rdata;
        end
    end

    // Indicator decode
    always_comb begin
        ind_mode = fdcr_pkg::FDCR_IND_OFF;
        if (indicator_level_code[3]) begin
            if ((mode_select == `FDCR_MODE_PWM_OK) && !torch_enable_pin) begin
                ind_mode = fdcr_pkg::FDCR_IND_PWM;
            end
        end else if (indicator_level_code[1:0] == `FDCR_LVL_OFF) begin
            ind_mode = fdcr_pkg::FDCR_IND_OFF;
        end else if (!indicator_level_code[2]) begin
            ind_mode = fdcr_pkg::FDCR_IND_DIRECT;
        end else if (!high_current_select) begin
            ind_mode = fdcr_pkg::FDCR_IND_PULLDOWN;
        end
    end

    // Dimming ratio per code
    always_comb begin
        case (indicator_level_code[2:0])
            3'h0: duty = `FDCR_DUTY_0;
            3'h1: duty = `FDCR_DUTY_1;
            3'h2: duty = `FDCR_DUTY_2;
            3'h3: duty = `FDCR_DUTY_3;
            3'h4: duty = `FDCR_DUTY_4;
            3'h5: duty = `FDCR_DUTY_5;
            3'h6: duty = `FDCR_DUTY_6;
            3'h7: duty = `FDCR_DUTY_7;
            default: duty = `FDCR_DUTY_0;
        endcase
    end

    assign step_en = (step_cnt_ff == 16'(PWM_STEP_CYC - 1));

    // Indicator outputs and PWM counters
    always_comb begin
        nxt_step_cnt = step_en ? 16'h0000 : 16'(step_cnt_ff + 16'h0001);
        nxt_phase = phase_ff;
        if (step_en) begin
            if (phase_ff == 10'(`FDCR_PWM_PERIOD - 10'h001)) begin
                nxt_phase = 10'h000;
            end else begin
                nxt_phase = 10'(phase_ff + 10'h001);
            end
        end
        nxt_lvl = `FDCR_LVL_OFF;
        nxt_pull = 1'b0;
        nxt_pwm_on = 1'b0;
        case (ind_mode)
            fdcr_pkg::FDCR_IND_DIRECT: begin
                nxt_lvl = indicator_level_code[1:0];
            end
            fdcr_pkg::FDCR_IND_PULLDOWN: begin
                nxt_lvl = indicator_level_code[1:0];
                nxt_pull = 1'b1;
            end
            fdcr_pkg::FDCR_IND_PWM: begin
                nxt_pwm_on = (nxt_phase < duty);
            end
            default: begin
                nxt_lvl = `FDCR_LVL_OFF;
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            step_cnt_ff <= 16'h0000;
            phase_ff <= 10'h000;
            pwm_on_ff <= 1'b0;
            lvl_ff <= `FDCR_LVL_OFF;
            pull_ff <= 1'b0;
        end else begin
            step_cnt_ff <= nxt_step_cnt;
            phase_ff <= nxt_phase;
            pwm_on_ff <= nxt_pwm_on;
            lvl_ff <= nxt_lvl;
            pull_ff <= nxt_pull;
        end
    end

    // Per-channel PWM gate, shut off by overheat
    genvar ch;
    generate
        for (ch = 0; ch < 3; ch++) begin : g_chan
            assign pwm_channel_on[ch] = pwm_on_ff && led_en_ff[ch] && !hot_ff;
        end
    endgenerate

    assign pwm_indicator_active = (ind_mode == fdcr_pkg::FDCR_IND_PWM);
    assign privacy_led_level = lvl_ff;
    assign privacy_led_pulldown = pull_ff;
    assign reg_rdata = rdata_ff;
    assign calibration_enable = cal_en_ff;
    assign calibration_start = cal_start_ff;
    assign power_save_enable = psm_ff;
    assign led_channel_enable = led_en_ff;
    assign target_output_code = ov_tgt_ff;
    assign constant_voltage_mode = voltage_mode_force;
    assign thermistor_monitor_enable = tmon_ff;
    assign thermal_shutdown = hot_ff;

    // Open-drain drives only a low level
    assign aux_pin_out = type_ff ? 1'b0 : val_ff;
    assign aux_pin_oe_n = !(dir_ff && (!type_ff || !val_ff));

endmodule // fdcr_regs

// [tb/fdcr_checker.sv]
/*
 * Concurrent checks on the ports of fdcr_regs, bound to every instance.
 * Assumes single-cycle register strobes and one core clock domain.
 */
`timescale 1ns/1ps

module fdcr_checker (
    input wire logic core_clk, // Core clock
    input wire logic rst, // Async reset
    input wire logic [7:0] reg_addr, // Address
    input wire logic reg_wr, // Write strobe
    input wire logic [7:0] reg_wdata, // Write data
    input wire logic [3:0] indicator_level_code, // Indicator code
    input wire logic [1:0] mode_select, // Mode select
    input wire logic high_current_select, // High-current select
    input wire logic torch_enable_pin, // Torch pin
    input wire logic [1:0] privacy_led_level, // Indicator current
    input wire logic privacy_led_pulldown, // Node pulldown
    input wire logic [2:0] pwm_channel_on, // PWM gates
    input wire logic pwm_indicator_active, // PWM mode
    input wire logic calibration_enable, // Calibration enable
    input wire logic calibration_start, // Start pulse
    input wire logic aux_pin_oe_n, // Aux enable, low drives
    input wire logic [2:0] led_channel_enable, // Channel enables
    input wire logic thermal_shutdown // Overheat latch
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    logic w5;
    logic [3:0] c;
    assign w5 = reg_wr && reg_addr == 8'h05;
    assign c = indicator_level_code;

    cal_start_a: assert property (w5 && reg_wdata[7] |=> calibration_start)
        else $error("calibration start pulse missing");
    cal_enable_a: assert property (w5 |=> calibration_enable == $past(reg_wdata[7]))
        else $error("calibration enable differs from written bit");
    chan_enable_a: assert property (w5 |=> led_channel_enable == $past(reg_wdata[2:0]))
        else $error("channel enables differ from written bits");
    dir_input_a: assert property (w5 && !reg_wdata[5] |=> aux_pin_oe_n)
        else $error("aux pin driven while input");
    push_pull_a: assert property (w5 && reg_wdata[5] && !reg_wdata[3] |=> !aux_pin_oe_n)
        else $error("push-pull output not driven");
    pwm_gate_a: assert property (pwm_indicator_active ==
        (c[3] && mode_select == 2'h1 && !torch_enable_pin))
        else $error("pwm indicator activation wrong");
    ind_off_a: assert property (!c[3] && c[1:0] == 2'h0 |=> privacy_led_level == 2'h0)
        else $error("indicator not off");
    ind_level_a: assert property (!c[3] && c[1:0] != 2'h0 &&
        !(c[2] && high_current_select) |=> privacy_led_level == $past(c[1:0]))
        else $error("indicator current step wrong");
    node_pulldown_a: assert property (1'b1 |=> privacy_led_pulldown ==
        $past(c[3:2] == 2'h1 && c[1:0] != 2'h0 && !high_current_select))
        else $error("pulldown state wrong");
    shut_gate_a: assert property (thermal_shutdown && $past(thermal_shutdown)
        |-> pwm_channel_on == 3'h0)
        else $error("pwm gates open during shutdown");

    cover property (calibration_start);
    cover property (thermal_shutdown);
    cover property (pwm_indicator_active && pwm_channel_on != 3'h0);
endmodule // fdcr_checker

bind fdcr_regs fdcr_checker i_chk (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .indicator_level_code(indicator_level_code),
    .mode_select(mode_select), .high_current_select(high_current_select),
    .torch_enable_pin(torch_enable_pin), .privacy_led_level(privacy_led_level),
    .privacy_led_pulldown(privacy_led_pulldown), .pwm_channel_on(pwm_channel_on),
    .pwm_indicator_active(pwm_indicator_active), .calibration_enable(calibration_enable),
    .calibration_start(calibration_start), .aux_pin_oe_n(aux_pin_oe_n),
    .led_channel_enable(led_channel_enable), .thermal_shutdown(thermal_shutdown));

// [tb/fdcr_cal_model.sv]
/*
 * Behavioural self-calibration engine facing the block.
 * Assumes a one-cycle start pulse; a new start restarts the run.
 */
`timescale 1ns/1ps

module fdcr_cal_model #(
    parameter int CAL_CYC = 20,
    parameter logic [3:0] RESULT = 4'h3
) (
    input wire logic core_clk, // Core clock
    input wire logic rst, // Async reset
    input wire logic calibration_start, // Start pulse
    output logic calibration_done, // One-cycle done pulse
    output logic [3:0] calibration_result // Valid with done only
);
    int cnt;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cnt <= 0;
            calibration_done <= 1'b0;
        end else begin
            calibration_done <= cnt == 1;
            if (calibration_start) cnt <= CAL_CYC;
            else if (cnt != 0) cnt <= cnt - 1;
        end
    end
    // Not a valid result outside the pulse
    assign calibration_result = calibration_done ? RESULT : ~RESULT;
endmodule // fdcr_cal_model

// [tb/tb_top.sv]
/*
 * Self-checking bench for fdcr_regs with a calibration engine model.
 * Assumes single-cycle register strobes and a 100 MHz core clock.
 */
`timescale 1ns/1ps

module tb_top;
    logic core_clk, rst, reg_wr, reg_rd, hcs, torch, vmf, cal_start, cal_done, pd, pwm_act;
    logic cal_en, pse, aux_ext, aux_out, aux_oe_n, fse, hdr_ok, cvm, tmon, hot, warn, shut;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic [3:0] code, cal_res, tgt;
    logic [2:0] pwm_on, led_en;
    logic [1:0] mode, lvl;
    wire aux_in = aux_oe_n ? aux_ext : aux_out;
    int num_errors = 0;
    int tests_run = 0;
    int cyc = 0;
    int n;

    fdcr_regs #(.HAS_THERMAL(1'b1), .PWM_STEP_CYC(2)) i_dut (
        .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .indicator_level_code(code), .mode_select(mode), .high_current_select(hcs),
        .torch_enable_pin(torch), .voltage_mode_force(vmf), .privacy_led_level(lvl),
        .privacy_led_pulldown(pd), .pwm_channel_on(pwm_on), .pwm_indicator_active(pwm_act),
        .calibration_enable(cal_en), .calibration_start(cal_start),
        .calibration_done(cal_done), .calibration_result(cal_res),
        .power_save_enable(pse), .aux_pin_in(aux_in), .aux_pin_out(aux_out),
        .aux_pin_oe_n(aux_oe_n), .led_channel_enable(led_en), .flash_strobe_end(fse),
        .headroom_ok(hdr_ok), .target_output_code(tgt), .constant_voltage_mode(cvm),
        .thermistor_monitor_enable(tmon), .ts_below_hot(hot), .ts_below_warn(warn),
        .thermal_shutdown(shut));

    fdcr_cal_model #(.CAL_CYC(20), .RESULT(4'h3)) i_cal (.core_clk(core_clk), .rst(rst),
        .calibration_start(cal_start), .calibration_done(cal_done),
        .calibration_result(cal_res));

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        cyc++;
        if (cyc > 12000) begin
            num_errors++;
            summarize();
        end
    end

    task automatic tick();
        @(posedge core_clk);
        #1;
    endtask

    task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        tick();
        reg_wr = 1'b0;
        tick();
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        reg_addr = a;
        reg_rd = 1'b1;
        tick();
        reg_rd = 1'b0;
        chk($sformatf("read %h", a), reg_rdata, exp);
        tick();
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        rst = 1'b1;
        {reg_wr, reg_rd, hcs, torch, vmf, fse, hdr_ok, hot, warn, aux_ext} = '0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        code = 4'h0;
        mode = 2'h0;
        repeat (8) @(posedge core_clk);
        #1;
        rst = 1'b0;
        rd(8'h05, 8'h4a);
        torch = 1'b1;
        rd(8'h05, 8'h6a);
        torch = 1'b0;
        rd(8'h06, 8'h09);
        wr(8'h07, 8'hff);
        rd(8'h07, 8'h00);
        rd(8'h05, 8'h4a);
        chk("psm", {7'h0, pse}, 8'h01);
        chk("aux_oe_n", {7'h0, aux_oe_n}, 8'h00);
        chk("cvm", {7'h0, cvm}, 8'h00);
        $display("reset test done");
        aux_ext = 1'b1;
        wr(8'h05, 8'h07);
        chk("psm", {7'h0, pse}, 8'h00);
        chk("led_en", {5'h0, led_en}, 8'h07);
        chk("aux_oe_n", {7'h0, aux_oe_n}, 8'h01);
        rd(8'h05, 8'h17);
        wr(8'h05, 8'h30);
        chk("aux drive", {6'h0, aux_oe_n, aux_out}, 8'h01);
        wr(8'h05, 8'h38);
        chk("aux_oe_n", {7'h0, aux_oe_n}, 8'h01);
        wr(8'h05, 8'h28);
        chk("aux_oe_n", {7'h0, aux_oe_n}, 8'h00);
        $display("aux pin test done");
        for (int k = 0; k < 2; k++) begin
            wr(8'h05, 8'h87);
            chk("cal_en", {7'h0, cal_en}, 8'h01);
            rd(8'h05, 8'h17);
            repeat (40) tick();
            rd(8'h05, 8'h97);
        end
        chk("target", {4'h0, tgt}, 8'h03);
        rd(8'h06, 8'h03);
        wr(8'h05, 8'h07);
        chk("cal_en", {7'h0, cal_en}, 8'h00);
        rd(8'h05, 8'h97);
        $display("calibration test done");
        vmf = 1'b1;
        wr(8'h06, 8'h8f);
        chk("cvm", {7'h0, cvm}, 8'h01);
        chk("target", {3'h0, tmon, tgt}, 8'h1f);
        hdr_ok = 1'b1;
        fse = 1'b1;
        tick();
        {fse, hdr_ok} = '0;
        tick();
        rd(8'h06, 8'h9f);
        fse = 1'b1;
        tick();
        fse = 1'b0;
        tick();
        rd(8'h06, 8'h8f);
        $display("headroom test done");
        mode = 2'h1;
        for (int k = 0; k < 2; k++) begin
            code = k ? 4'hf : 4'h8;
            repeat (4) tick();
            chk("pwm_act", {7'h0, pwm_act}, 8'h01);
            n = 0;
            repeat (2000) begin
                tick();
                n += (pwm_on === 3'h7);
            end
            chk("pwm on cycles", n[7:0], k ? 8'hac : 8'h10);
        end
        $display("pwm test done");
        warn = 1'b1;
        repeat (4) tick();
        rd(8'h06, 8'haf);
        rd(8'h06, 8'haf);
        warn = 1'b0;
        repeat (4) tick();
        rd(8'h06, 8'haf);
        rd(8'h06, 8'h8f);
        hot = 1'b1;
        repeat (6) tick();
        chk("shutdown", {7'h0, shut}, 8'h01);
        hot = 1'b0;
        repeat (4) tick();
        rd(8'h06, 8'hcf);
        wr(8'h06, 8'hcf);
        chk("shutdown", {7'h0, shut}, 8'h01);
        wr(8'h06, 8'h8f);
        chk("shutdown", {7'h0, shut}, 8'h00);
        $display("thermal test done");
        torch = 1'b1;
        tick();
        chk("pwm_act", {7'h0, pwm_act}, 8'h00);
        vmf = 1'b1;
        tick();
        chk("cvm", {7'h0, cvm}, 8'h01);
        mode = 2'h0;
        for (int i = 0; i < 32; i++) begin
            code = i[3:0];
            hcs = i[4];
            tick();
            tick();
            if (!i[3]) begin
                chk("level", {6'h0, lvl}, (i[2] && i[4]) ? 8'h00 : {6'h0, i[1:0]});
                chk("pulldown", {7'h0, pd}, {7'h0, i[2] && !i[4] && i[1:0] != 0});
            end else begin
                chk("pwm_act", {7'h0, pwm_act}, 8'h00);
            end
        end
        $display("indicator test done");
        summarize();
    end
endmodule // tb_top
